// ---- design/flash_adc_conversion_sequencer.v ----
// Notes on behaviour
// - One conversion per converter clock period
// - Phase low: balance high, sample low
// - Phase select inverts the incoming clock
// - Sample end latches all 64 comparators
// - Decoded 6-bit code and overflow load at next sample start
// - Active-low enable high floats data bits only
// - Active-high enable low floats all outputs
// - Phase high: rising edge starts sampling
// - Next rising edge loads code, starts sampling
// - Single balance pulse: capture then load
// - Two sample pulses: latch, then load
// - Two balance pulses give data in two cycles
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_defs.vh"

module flash_adc_conversion_sequencer #(
  parameter N = `CMP_COUNT,
  parameter W = `CODE_W,
  parameter ADDR_W = 8,
  parameter DROOP_CYCLES = `DROOP_CYC
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  // Converter clock and polarity select, synchronous to clk_sys_i
  input wire conv_clk_i,
  input wire phase_sel_i,
  // Comparator states: low means tap below the input
  input wire [N-1:0] comparator_i,
  // Output enables
  input wire enable_active_low_n_i,
  input wire enable_active_high_i,
  // Parallel code and its drive enables
  output reg [W-1:0] code_bits_o,
  output reg code_bits_oe_o,
  output reg overflow_flag_o,
  output reg overflow_flag_oe_o,
  // Wishbone slave
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Level interrupt
  output reg irq_o
);

  // Phase tracker states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SAMPLE = 3'b010;
  localparam [2:0] ST_BALANCE = 3'b100;

  // Width of the droop counter, generous for any sane parameter
  localparam CW = 16;
  // Droop limit in system clocks. It is cut to the counter width, so
  // a limit of 65536 or more would wrap; keep DROOP_CYCLES below it.
  localparam [CW-1:0] DROOP_LIMIT = DROOP_CYCLES[CW-1:0];

  // Current phase state
  reg [2:0] state;
  // Next phase state
  reg [2:0] next_state;

  // Comparator latch stage
  reg [N-1:0] cmp_latch;
  // Latch holds a result not yet loaded to the outputs
  reg pending;

  // Control register
  reg [1:0] ctrl;
  // Sticky event flags
  reg [`ST_W-1:0] status;
  // Interrupt mask
  reg [`ST_W-1:0] mask;
  // Completed conversion count
  reg [15:0] conv_count;
  // Cycles spent standing in the sample phase
  reg [CW-1:0] droop_cnt;
  // Droop already reported for this standby
  reg droop_seen;

  // Decoder outputs
  wire [W-1:0] dec_code;
  wire dec_over;

  // Internal phase: sample when clock matches the polarity select.
  // Select low makes the low clock half the sample half.
  wire sample_now = ~(conv_clk_i ^ phase_sel_i);

  // Edge events on the internal phase, only while running
  wire run = ctrl[`CTRL_RUN_BIT];
  wire sample_start = run && state == ST_BALANCE && sample_now;
  wire sample_end = run && state == ST_SAMPLE && !sample_now;

  // Bus decode helpers.
  // A request counts only while ack is low, so a strobe that is held
  // too long is not answered twice back to back.
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  // Events that set status flags this cycle.
  // Done marks a real load, never a bare phase change.
  wire ev_done = sample_start && pending;
  wire ev_over = ev_done && dec_over;
  wire ev_droop = run && ctrl[`CTRL_WATCH_BIT] && state == ST_SAMPLE &&
                  droop_cnt == DROOP_LIMIT && !droop_seen;
  wire [`ST_W-1:0] ev_vec = {ev_droop, ev_over, ev_done};

  // Decode of the latched comparator states
  thermo_decode #(
    .N(N),
    .W(W)
  ) u_decode (
    .comp_i(cmp_latch),
    .code_o(dec_code),
    .over_o(dec_over)
  );

  // Phase tracker next state.
  // Idle picks up the present phase without creating an edge, so
  // the first converter half after reset or run-enable is not
  // mistaken for a phase boundary.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run) begin
          next_state = sample_now ? ST_SAMPLE : ST_BALANCE;
        end
      end
      ST_SAMPLE: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (!sample_now) begin
          next_state = ST_BALANCE;
        end
      end
      ST_BALANCE: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (sample_now) begin
          next_state = ST_SAMPLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Phase state register
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Comparator latch and output storage register.
  // Every mode (continuous, one balance pulse, two sample pulses,
  // two balance pulses) reduces to the same pair of edges: sample
  // end captures, the following sample start loads. Pulse modes
  // therefore need no mode setting of their own.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmp_latch <= {N{1'b1}};
      pending <= 1'b0;
      code_bits_o <= {W{1'b0}};
      overflow_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (sample_end) begin
        // Capture all comparators at the end of sampling
        cmp_latch <= comparator_i;
        pending <= 1'b1;
      end else if (sample_start && pending) begin
        // Load decoded code as the next sample phase begins
        code_bits_o <= dec_code;
        overflow_flag_o <= dec_over;
        pending <= 1'b0;
      end
    end
  end

  // Output drive enables.
  // The active-high enable overrides; the active-low enable only
  // gates the data bits, leaving overflow driven for cascading.
  // Both enables are registered, so the drive timing trails the
  // enable pins by one system clock.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      code_bits_oe_o <= 1'b0;
      overflow_flag_oe_o <= 1'b0;
    end else if (ce_i) begin
      code_bits_oe_o <= enable_active_high_i && !enable_active_low_n_i;
      overflow_flag_oe_o <= enable_active_high_i;
    end
  end

  // Sample-phase standby watchdog.
  // Held charge droops if the sample phase stands too long, so the
  // block reports it; it cannot restore accuracy, only flag it.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      droop_cnt <= {CW{1'b0}};
      droop_seen <= 1'b0;
    end else if (ce_i) begin
      if (state != ST_SAMPLE || !sample_now) begin
        // Any balance phase restarts the standby measurement
        droop_cnt <= {CW{1'b0}};
        droop_seen <= 1'b0;
      end else if (droop_cnt != DROOP_LIMIT) begin
        droop_cnt <= droop_cnt + 1'b1;
      end else if (ev_droop) begin
        // Report once per standby
        droop_seen <= 1'b1;
      end
    end
  end

  // Conversion counter, wraps silently
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      conv_count <= 16'h0000;
    end else if (ce_i && ev_done) begin
      conv_count <= conv_count + 16'h0001;
    end
  end

  // Control and mask registers, low byte lane only
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
      mask <= `MASK_RESET;
    end else if (ce_i && bus_wr) begin
      if (wb_adr_i == `OFS_CTRL) begin
        ctrl <= wb_dat_i[1:0];
      end else if (wb_adr_i == `OFS_MASK) begin
        mask <= wb_dat_i[`ST_W-1:0];
      end
    end
  end

  // Sticky status, write one to clear.
  // A new event in the clearing cycle survives: set wins.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      status <= {`ST_W{1'b0}};
    end else if (ce_i) begin
      if (bus_wr && wb_adr_i == `OFS_STATUS) begin
        status <= (status & ~wb_dat_i[`ST_W-1:0]) | ev_vec;
      end else begin
        status <= status | ev_vec;
      end
    end
  end

  // Interrupt level, registered so the port comes from a flop.
  // It trails the status register by one cycle.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status & mask);
    end
  end

  // Bus answer: one cycle after the request, dropped the cycle after.
  // Unmapped offsets are acknowledged and read as zero.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == `OFS_CTRL) begin
          wb_dat_o <= {30'h00000000, ctrl};
        end else if (wb_adr_i == `OFS_STATUS) begin
          wb_dat_o <= {29'h00000000, status};
        end else if (wb_adr_i == `OFS_MASK) begin
          wb_dat_o <= {29'h00000000, mask};
        end else if (wb_adr_i == `OFS_CODE) begin
          // Stored code, present phase and pending latch
          wb_dat_o <= {22'h000000, pending, sample_now, 1'b0,
                       overflow_flag_o, code_bits_o};
        end else if (wb_adr_i == `OFS_COUNT) begin
          wb_dat_o <= {16'h0000, conv_count};
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- design/flash_seq_defs.vh ----
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH

// Converter geometry
`define CMP_COUNT 64
`define CODE_W 6

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_CODE 8'h0c
`define OFS_COUNT 8'h10

// Control fields
`define CTRL_RUN_BIT 0
`define CTRL_WATCH_BIT 1
`define CTRL_RESET 2'h3

// Status and mask fields
`define ST_DONE_BIT 0
`define ST_OVER_BIT 1
`define ST_DROOP_BIT 2
`define ST_W 3
`define MASK_RESET 3'h0

// Code register fields
`define CODE_PHASE_BIT 8
`define CODE_PEND_BIT 9

// Timing
`define CLK_PERIOD_NS 10
`define DROOP_NS 5000
`define DROOP_CYC (`DROOP_NS / `CLK_PERIOD_NS)

`endif

// ---- design/thermo_decode.v ----
`timescale 1ns/1ns
`default_nettype none

// Counts comparators that report a tap below the input (low outputs).
// A full count of all comparators is the overflow case.
module thermo_decode #(
  parameter N = 64,
  parameter W = 6
) (
  input wire [N-1:0] comp_i,
  output wire [W-1:0] code_o,
  output wire over_o
);

  // Running count of low comparators, one stage per comparator
  wire [W:0] cnt [0:N];

  assign cnt[0] = {(W+1){1'b0}};

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_cnt
      // Each low comparator adds one to the running count
      assign cnt[i+1] = cnt[i] + {{W{1'b0}}, ~comp_i[i]};
    end
  endgenerate

  // Full count sets overflow; data bits then saturate to all ones
  assign over_o = cnt[N][W];
  assign code_o = over_o ? {W{1'b1}} : cnt[N][W-1:0];

endmodule

`default_nettype wire

// ---- testbench/adc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Host side: makes the converter clock and watches the shared data lines
module adc_host_model (
  input wire logic clk_i,
  input wire logic go_i, // Run the converter clock
  input wire logic idle_i, // Level parked while stopped
  input wire logic [7:0] hi_len_i,
  input wire logic [7:0] lo_len_i,
  input wire logic [5:0] code_bits_i,
  input wire logic code_bits_oe_i,
  input wire logic overflow_flag_i,
  input wire logic overflow_flag_oe_i,
  output logic conv_clk_o = 1'b1,
  output logic [6:0] seen_o
);
  logic [7:0] cnt = 8'h1; // Cycles spent in the current half
  logic [6:0] last = 7'h0; // Last line levels
  // Half lengths come from the bench, which keeps a sample standby short
  always @(posedge clk_i) begin
    if (!go_i) begin
      conv_clk_o <= idle_i;
      cnt <= 8'h1;
    end else if (cnt >= (conv_clk_o ? hi_len_i : lo_len_i)) begin
      conv_clk_o <= !conv_clk_o;
      cnt <= 8'h1;
    end else begin
      cnt <= cnt + 8'h1;
    end
  end
  // A floated line flips every cycle, so stale data can never pass
  assign seen_o = {overflow_flag_oe_i ? overflow_flag_i : ~last[6],
                   code_bits_oe_i ? code_bits_i : ~last[5:0]};
  always @(posedge clk_i) last <= seen_o;
endmodule
`default_nettype wire

// ---- testbench/flash_adc_conversion_sequencer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module flash_adc_conversion_sequencer_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic conv_clk_i;
  logic phase_sel_i = 1'b0;
  logic [63:0] comparator_i = 64'h0;
  logic enable_active_low_n_i = 1'b0;
  logic enable_active_high_i = 1'b1;
  logic [5:0] code_bits_o;
  logic code_bits_oe_o;
  logic overflow_flag_o;
  logic overflow_flag_oe_o;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic go = 1'b0; // Host clock running
  logic idle = 1'b1; // Parked clock level
  logic [7:0] hi_len = 8'h2;
  logic [7:0] lo_len = 8'h2;
  logic [6:0] seen; // Resolved data lines
  logic [31:0] rd;
  logic [31:0] c0;
  int checks = 0;
  int fail_count = 0;
  // Modes: standby sample, standby balance, then both with the clock inverted
  bit psel_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [7:0] hi_tab [4] = '{8'd2, 8'd20, 8'd6, 8'd2};
  logic [7:0] lo_tab [4] = '{8'd6, 8'd2, 8'd2, 8'd20};
  // Short watchdog span keeps droop tests quick
  flash_adc_conversion_sequencer #(.DROOP_CYCLES(8)) u_flash_adc_conversion_sequencer (.*);
  adc_host_model u_adc_host_model (.clk_i(clk_sys_i), .go_i(go), .idle_i(idle),
    .hi_len_i(hi_len), .lo_len_i(lo_len), .code_bits_i(code_bits_o),
    .code_bits_oe_i(code_bits_oe_o), .overflow_flag_i(overflow_flag_o),
    .overflow_flag_oe_i(overflow_flag_oe_o), .conv_clk_o(conv_clk_i), .seen_o(seen));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_sys_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    do begin
      @(posedge clk_sys_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // Thermometer count of low comparators; all low is overflow
  function automatic logic [6:0] expect_code(input logic [63:0] c);
    int z;
    z = 0;
    for (int i = 0; i < 64; i++) z += !c[i];
    return (z == 64) ? 7'h7f : 7'(z);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
  initial begin
    void'($urandom(32'h5e9d));
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Reset values, then one unmapped place reading zero
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      check(rd, (i == 0) ? 32'h3 : 32'h0);
    end
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      {phase_sel_i, hi_len, lo_len, go} <= {psel_tab[m], hi_tab[m], lo_tab[m], 1'b1};
      for (int k = 0; k < 6; k++) begin
        comparator_i <= {64{1'b1}} << ((k == 0) ? 64 : (k == 1) ? 0 : $urandom % 64);
        repeat (3 * (hi_tab[m] + lo_tab[m]) + 4) @(posedge clk_sys_i);
        check(seen, expect_code(comparator_i));
      end
      if (m == 0) begin
        wb(1'b0, 8'h10, 32'h0);
        c0 = rd;
        // Count captures end up 80 edges apart: ten eight-cycle periods
        repeat (77) @(posedge clk_sys_i);
        wb(1'b0, 8'h10, 32'h0);
        check(rd - c0, 32'd10);
      end
      $display("test mode %0d done", m);
    end
    // Done event raises the interrupt, writing one clears it
    wb(1'b1, 8'h08, 32'h1);
    {phase_sel_i, idle} <= 2'b01;
    repeat (40) @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    check(irq_o, 1'b1);
    wb(1'b1, 8'h04, 32'h7);
    repeat (3) @(posedge clk_sys_i);
    check(irq_o, 1'b0);
    // Parked in the sample half too long: droop flagged
    idle <= 1'b0;
    wb(1'b1, 8'h08, 32'h4);
    repeat (20) @(posedge clk_sys_i);
    check(irq_o, 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    check(rd[2], 1'b1);
    $display("test interrupt done");
    // Every enable pair, drive enables checked three cycles later
    for (int e = 0; e < 4; e++) begin
      {enable_active_high_i, enable_active_low_n_i} <= 2'(e);
      repeat (3) @(posedge clk_sys_i);
      check({code_bits_oe_o, overflow_flag_oe_o}, {e == 2, e > 1});
    end
    $display("test enables done");
    // Clock enable low freezes the drive enables; they follow once it returns
    {ce_i, enable_active_high_i, enable_active_low_n_i} <= 3'b010;
    repeat (3) @(posedge clk_sys_i);
    check({code_bits_oe_o, overflow_flag_oe_o}, 2'b01);
    ce_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check({code_bits_oe_o, overflow_flag_oe_o}, 2'b11);
    $display("test clock enable done");
    final_report;
  end
endmodule
`default_nettype wire

// ---- testbench/flash_seq_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
// Pin-level checks of the sequencer, all in the system clock domain
module flash_seq_checker #(
  parameter W = 6
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic conv_clk_i,
  input wire logic phase_sel_i,
  input wire logic enable_active_low_n_i,
  input wire logic enable_active_high_i,
  input wire logic [W-1:0] code_bits_o,
  input wire logic code_bits_oe_o,
  input wire logic overflow_flag_o,
  input wire logic overflow_flag_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // High in the sample half, polarity select applied
  wire logic in_sample = (conv_clk_i == phase_sel_i);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  chk_ack_drop: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_read_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_data_float: assert property (
    ce_i && enable_active_low_n_i && enable_active_high_i
    |=> !code_bits_oe_o && overflow_flag_oe_o) else $error("data bits not floated");
  chk_both_drive: assert property (
    ce_i && !enable_active_low_n_i && enable_active_high_i
    |=> code_bits_oe_o && overflow_flag_oe_o) else $error("outputs not driven");
  chk_all_float: assert property (
    ce_i && !enable_active_high_i |=> !code_bits_oe_o && !overflow_flag_oe_o)
    else $error("outputs not floated");
  chk_load_edge: assert property (
    $changed({code_bits_o, overflow_flag_o}) && !$past(rst_i)
    |-> $past(in_sample) && !$past(in_sample, 2)) else $error("code loaded off sample start");
  chk_load_spacing: assert property (
    $changed({code_bits_o, overflow_flag_o}) && !$past(rst_i)
    |=> $stable({code_bits_o, overflow_flag_o})) else $error("two loads in a row");
  chk_over_full: assert property (overflow_flag_o |-> code_bits_o == {W{1'b1}})
    else $error("overflow without full data bits");
endmodule
bind flash_adc_conversion_sequencer flash_seq_checker #(.W(W)) u_flash_seq_checker (.*);
`default_nettype wire
